// [common/synth_pkg.sv]
// constants, pin groups and state records shared by the synthesizer core
`default_nettype none
package synth_pkg;
  // counter widths
  localparam int unsigned DIV_W = 15;
  localparam int unsigned NPROG_W = 14;
  localparam int unsigned REFSEL_W = 3;
  localparam int unsigned PULSE_W = 4;
  // total reference divide values
  localparam logic [DIV_W-1:0] REF_DIV_CODE0 = 15'h0008;
  localparam logic [DIV_W-1:0] REF_DIV_CODE1 = 15'h0080;
  localparam logic [DIV_W-1:0] REF_DIV_CODE2 = 15'h0100;
  localparam logic [DIV_W-1:0] REF_DIV_CODE3 = 15'h0200;
  localparam logic [DIV_W-1:0] REF_DIV_CODE4 = 15'h0400;
  localparam logic [DIV_W-1:0] REF_DIV_CODE5 = 15'h0800;
  localparam logic [DIV_W-1:0] REF_DIV_CODE6 = 15'h096a;
  localparam logic [DIV_W-1:0] REF_DIV_CODE7 = 15'h2000;
  // divide-by-n limits and transmit/receive offset
  localparam logic [DIV_W-1:0] N_MIN = 15'h0003;
  localparam logic [DIV_W-1:0] N_MAX = 15'h3fff;
  localparam logic [DIV_W-1:0] TR_OFFSET = 15'h0358;
  localparam logic [DIV_W-1:0] DIV_ZERO = 15'h0000;
  localparam logic [DIV_W-1:0] DIV_ONE = 15'h0001;
  // minimum width of the coincident phase detector pulse
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MIN_PULSE_NS = 16;
  localparam int unsigned MIN_PULSE_CYC_I =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [PULSE_W-1:0] MIN_PULSE_CYC =
    (MIN_PULSE_CYC_I < 1) ? 4'h1 : PULSE_W'(MIN_PULSE_CYC_I);
  localparam logic [PULSE_W-1:0] PULSE_ZERO = 4'h0;
  localparam logic [PULSE_W-1:0] PULSE_ONE = 4'h1;

  // static programming pins, bit 13 of divn_prog is divn_prog_msb, bit 0 divn_prog_lsb
  typedef struct packed {
    logic ref_sel_bit2;
    logic ref_sel_bit1;
    logic ref_sel_bit0;
    logic tx_rx_sel;
    logic [NPROG_W-1:0] divn_prog;
  } prog_pins_t;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_VCO_LEAD = 2'b01,
    PFD_REF_LEAD = 2'b10,
    PFD_BOTH = 2'b11
  } pfd_state_t;

  typedef struct packed {
    logic level;
    logic wrap;
    logic [DIV_W-1:0] cnt;
  } div_state_t;

  typedef struct packed {
    logic vco_s1;
    logic vco_s2;
    logic vco_s3;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    prog_pins_t prog_s1;
    prog_pins_t prog_s2;
    prog_pins_t drive_s1;
    prog_pins_t drive_s2;
    pfd_state_t pfd;
    logic [PULSE_W-1:0] pulse_cnt;
    logic pend_vco;
    logic pend_ref;
    logic phi_vco_n;
    logic phi_ref_n;
    logic pd_level;
    logic pd_oe;
    logic lock_det;
    logic divn_out;
    logic osc_out;
  } core_state_t;
endpackage
`default_nettype wire

// [core/prog_div.sv]
// programmable down-counting divider with reload at zero
`default_nettype none
module prog_div (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // count input
  input wire logic tick,
  input wire logic [synth_pkg::DIV_W-1:0] ratio,
  // divided outputs
  output logic div_level,
  output logic div_wrap
);
  import synth_pkg::*;

  div_state_t state_ff;
  div_state_t nxt_state;
  logic [DIV_W-1:0] half;

  assign half = ratio >> 1;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.wrap = 1'b0;
    if (tick) begin
      if (state_ff.cnt == DIV_ZERO) begin
        // count length taken from ratio only here; half, the level threshold, follows ratio every cycle
        nxt_state.cnt = ratio - DIV_ONE;
        nxt_state.wrap = 1'b1;
      end else begin
        nxt_state.cnt = state_ff.cnt - DIV_ONE;
      end
    end
    nxt_state.level = (nxt_state.cnt >= half);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign div_level = state_ff.level;
  assign div_wrap = state_ff.wrap;
endmodule
`default_nettype wire

// [core/pll_synth_core.sv]
// digital core of a parallel-programmed single-modulus frequency synthesizer
//
// Behaviour
// - reference divide from select code: 8,128,256,512,1024,2048,2410,8192
// - divide-by-n counter reloads programmed value at zero, then keeps counting
// - fourteen n inputs form a binary number, bit 0 least significant
// - n ratio supported from 3 to 16383; source keeps within range
// - transmit/receive select low adds 856 to n, high adds nothing
// - unconnected select, n or transmit/receive inputs read as one
// - single-ended output low when vco leads, high when lagging, else floats
// - vco fast or leading: vco-side pulse low, reference-side stays high
// - vco slow or lagging: reference-side pulse low, vco-side stays high
// - in lock both pulse outputs high except brief coincident low pulse
// - divided vco signal is buffered onto its own output pin
// - lock output high while locked, pulses low while out of lock
`default_nettype none
module pll_synth_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // reference oscillator
  input wire logic ref_osc_input,
  output logic ref_osc_output,
  // vco input
  input wire logic vco_input,
  // programming pins and their drive state
  input wire synth_pkg::prog_pins_t prog_level,
  input wire synth_pkg::prog_pins_t prog_drive,
  // single-ended phase error, three signals of a three-state pin
  output logic single_ended_phase_error_i,
  output logic single_ended_phase_error_o,
  output logic single_ended_phase_error_oe,
  // double-ended phase error pair
  output logic phi_vco_n,
  output logic phi_ref_n,
  // counter output and lock
  output logic divn_out,
  output logic lock_det
);
  import synth_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // an undriven pin floats up to one through its pull-up
  function automatic prog_pins_t resolve_pins(input prog_pins_t lvl, input prog_pins_t drv);
    resolve_pins = lvl | ~drv;
  endfunction

  // a rising edge seen between two synchroniser stages
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic [DIV_W-1:0] ref_ratio(input logic [REFSEL_W-1:0] code);
    case (code)
      3'h0: ref_ratio = REF_DIV_CODE0;
      3'h1: ref_ratio = REF_DIV_CODE1;
      3'h2: ref_ratio = REF_DIV_CODE2;
      3'h3: ref_ratio = REF_DIV_CODE3;
      3'h4: ref_ratio = REF_DIV_CODE4;
      3'h5: ref_ratio = REF_DIV_CODE5;
      3'h6: ref_ratio = REF_DIV_CODE6;
      3'h7: ref_ratio = REF_DIV_CODE7;
      default: ref_ratio = REF_DIV_CODE7;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] n_ratio(input prog_pins_t p);
    logic [DIV_W-1:0] base;
    logic [DIV_W-1:0] sum;
    base = {1'b0, p.divn_prog};
    // low values would stall the counter; held at the floor instead
    if (base < N_MIN) begin
      base = N_MIN;
    end else if (base > N_MAX) begin
      base = N_MAX;
    end
    if (p.tx_rx_sel) begin
      sum = base;
    end else begin
      sum = base + TR_OFFSET;
    end
    n_ratio = sum;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // phase detector decodes

  // entry state from the edges seen this cycle; same at rest and at pulse end
  function automatic pfd_state_t pfd_enter(input logic v, input logic r);
    if (v && r) begin
      pfd_enter = PFD_BOTH;
    end else if (v) begin
      pfd_enter = PFD_VCO_LEAD;
    end else if (r) begin
      pfd_enter = PFD_REF_LEAD;
    end else begin
      pfd_enter = PFD_IDLE;
    end
  endfunction

  // pulse pair sides, both low through the coincident pulse
  function automatic logic vco_side_low(input pfd_state_t st);
    vco_side_low = (st == PFD_VCO_LEAD) || (st == PFD_BOTH);
  endfunction

  function automatic logic ref_side_low(input pfd_state_t st);
    ref_side_low = (st == PFD_REF_LEAD) || (st == PFD_BOTH);
  endfunction

  // lead states are the only out-of-lock states
  function automatic logic in_lead(input pfd_state_t st);
    in_lead = (st == PFD_VCO_LEAD) || (st == PFD_REF_LEAD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  core_state_t state_ff;
  core_state_t nxt_state;
  prog_pins_t pins_resolved;
  logic vco_tick;
  logic ref_tick;
  logic [DIV_W-1:0] ref_div_ratio;
  logic [DIV_W-1:0] n_div_ratio;
  logic n_level;
  logic n_wrap;
  logic r_level;
  logic r_wrap;
  logic vco_edge;
  logic ref_edge;

  // edge detectors read only the second and third sync stages
  assign vco_tick = rise(state_ff.vco_s2, state_ff.vco_s3);
  assign ref_tick = rise(state_ff.ref_s2, state_ff.ref_s3);

  ////////////////////////////////////////////////////////////////////////////
  // programming pins

  // merged only after both syncs, so a moving switch cannot glitch the code
  assign pins_resolved = resolve_pins(state_ff.prog_s2, state_ff.drive_s2);
  assign ref_div_ratio = ref_ratio({pins_resolved.ref_sel_bit2,
                                    pins_resolved.ref_sel_bit1,
                                    pins_resolved.ref_sel_bit0});
  assign n_div_ratio = n_ratio(pins_resolved);

  ////////////////////////////////////////////////////////////////////////////
  // dividers

  // one counter design for both ratios; a new ratio sets the period only at reload, the level threshold at once
  prog_div u_ref_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(ref_tick),
    .ratio(ref_div_ratio),
    .div_level(r_level),
    .div_wrap(r_wrap)
  );

  prog_div u_n_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(vco_tick),
    .ratio(n_div_ratio),
    .div_level(n_level),
    .div_wrap(n_wrap)
  );

  // wrap marks the rising edge of each divided signal
  assign vco_edge = n_wrap;
  assign ref_edge = r_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_state = state_ff;

    // synchronisers for every pin input: three stages for vco and reference, two for the programming pins
    nxt_state.vco_s1 = vco_input;
    nxt_state.vco_s2 = state_ff.vco_s1;
    nxt_state.vco_s3 = state_ff.vco_s2;
    nxt_state.ref_s1 = ref_osc_input;
    nxt_state.ref_s2 = state_ff.ref_s1;
    nxt_state.ref_s3 = state_ff.ref_s2;
    nxt_state.prog_s1 = prog_level;
    nxt_state.prog_s2 = state_ff.prog_s1;
    nxt_state.drive_s1 = prog_drive;
    nxt_state.drive_s2 = state_ff.drive_s1;

    // phase/frequency detector: first edge opens a pulse, second closes it
    case (state_ff.pfd)
      PFD_IDLE: begin
        nxt_state.pulse_cnt = PULSE_ZERO;
        nxt_state.pfd = pfd_enter(vco_edge, ref_edge);
      end
      PFD_VCO_LEAD: begin
        // a repeat vco edge is absorbed; only the reference edge ends the lead
        if (ref_edge) begin
          nxt_state.pfd = PFD_BOTH;
          nxt_state.pulse_cnt = PULSE_ZERO;
        end
      end
      PFD_REF_LEAD: begin
        // a repeat reference edge is absorbed; only the vco edge ends the lead
        if (vco_edge) begin
          nxt_state.pfd = PFD_BOTH;
          nxt_state.pulse_cnt = PULSE_ZERO;
        end
      end
      PFD_BOTH: begin
        // edges seen during the reset pulse are kept, not dropped
        if (vco_edge) begin
          nxt_state.pend_vco = 1'b1;
        end
        if (ref_edge) begin
          nxt_state.pend_ref = 1'b1;
        end
        if (state_ff.pulse_cnt >= MIN_PULSE_CYC - PULSE_ONE) begin
          nxt_state.pulse_cnt = PULSE_ZERO;
          nxt_state.pend_vco = 1'b0;
          nxt_state.pend_ref = 1'b0;
          nxt_state.pfd = pfd_enter(state_ff.pend_vco || vco_edge,
                                    state_ff.pend_ref || ref_edge);
        end else begin
          nxt_state.pulse_cnt = state_ff.pulse_cnt + PULSE_ONE;
        end
      end
      default: begin
        nxt_state.pfd = PFD_IDLE;
        nxt_state.pulse_cnt = PULSE_ZERO;
      end
    endcase

    // double-ended pair: low while its side leads, both low in coincidence
    nxt_state.phi_vco_n = ~vco_side_low(nxt_state.pfd);
    nxt_state.phi_ref_n = ~ref_side_low(nxt_state.pfd);

    // single-ended: drives only while exactly one side leads
    case (nxt_state.pfd)
      PFD_VCO_LEAD: begin
        nxt_state.pd_level = 1'b0;
        nxt_state.pd_oe = 1'b1;
      end
      PFD_REF_LEAD: begin
        nxt_state.pd_level = 1'b1;
        nxt_state.pd_oe = 1'b1;
      end
      default: begin
        nxt_state.pd_level = 1'b0;
        nxt_state.pd_oe = 1'b0;
      end
    endcase

    // lock pulses low only for the span of an error pulse
    nxt_state.lock_det = ~in_lead(nxt_state.pfd);

    // buffered counter output, the level of the divider whose wrap the detector sees
    nxt_state.divn_out = n_level;

    // oscillator inverter copy; lags the pin by the sync delay
    nxt_state.osc_out = ~state_ff.ref_s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= '0;
      state_ff.prog_s1 <= '1;
      state_ff.prog_s2 <= '1;
      state_ff.drive_s1 <= '1;
      state_ff.drive_s2 <= '1;
      state_ff.pd_oe <= 1'b0;
      state_ff.pd_level <= 1'b0;
      state_ff.divn_out <= 1'b0;
      state_ff.pfd <= PFD_IDLE;
      state_ff.phi_vco_n <= 1'b1;
      state_ff.phi_ref_n <= 1'b1;
      state_ff.lock_det <= 1'b1;
      state_ff.osc_out <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign ref_osc_output = state_ff.osc_out;
  assign single_ended_phase_error_i = 1'b0;
  assign single_ended_phase_error_o = state_ff.pd_level;
  assign single_ended_phase_error_oe = state_ff.pd_oe;
  assign phi_vco_n = state_ff.phi_vco_n;
  assign phi_ref_n = state_ff.phi_ref_n;
  assign divn_out = state_ff.divn_out;
  assign lock_det = state_ff.lock_det;
endmodule
`default_nettype wire

// [sim/pll_synth_core_assertions.sv]
// concurrent checks on the synthesizer core ports
`default_nettype none
module pll_synth_core_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // input pins
  input wire logic ref_osc_input,
  input wire logic vco_input,
  input wire synth_pkg::prog_pins_t prog_level,
  input wire synth_pkg::prog_pins_t prog_drive,
  // outputs
  input wire logic ref_osc_output,
  input wire logic single_ended_phase_error_i,
  input wire logic single_ended_phase_error_o,
  input wire logic single_ended_phase_error_oe,
  input wire logic phi_vco_n,
  input wire logic phi_ref_n,
  input wire logic divn_out,
  input wire logic lock_det
);
  import synth_pkg::*;
  typedef struct packed {logic d1; logic d2; logic d3;} hist_t;
  hist_t hist_ff;
  hist_t nxt_hist;
  logic both_low;
  logic oe;
  logic lvl;
  logic vco_rise_seen;
  assign both_low = !phi_vco_n && !phi_ref_n;
  assign oe = single_ended_phase_error_oe;
  assign lvl = single_ended_phase_error_o;
  // counter output high now and low three samples back
  assign vco_rise_seen = divn_out && !hist_ff.d3;
  always_comb begin
    nxt_hist = {divn_out, hist_ff.d1, hist_ff.d2};
  end
  // reset to ones so no rise is seen out of reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hist_ff <= 3'h7;
    end else begin
      hist_ff <= nxt_hist;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  vco_lead_pd_a: assert property (!phi_vco_n && phi_ref_n |-> oe && !lvl)
    else $error("pd level wrong in vco lead");
  ref_lead_pd_a: assert property (phi_vco_n && !phi_ref_n |-> oe && lvl)
    else $error("pd level wrong in ref lead");
  match_float_a: assert property (phi_vco_n == phi_ref_n |-> !oe)
    else $error("pd driven while matched");
  lock_flag_a: assert property (lock_det == (phi_vco_n == phi_ref_n))
    else $error("lock flag disagrees with detector");
  coinc_width_a: assert property ($rose(both_low) |=> both_low ##1 !both_low)
    else $error("coincident pulse width wrong");
  vco_fall_cause_a: assert property ($fell(phi_vco_n) && phi_ref_n |-> vco_rise_seen)
    else $error("vco pulse without counter edge");
  vco_lead_end_a: assert property (!phi_vco_n && phi_ref_n |=> !phi_vco_n)
    else $error("vco lead ended without coincidence");
  ref_lead_end_a: assert property (phi_vco_n && !phi_ref_n |=> !phi_ref_n)
    else $error("ref lead ended without coincidence");
  osc_copy_a: assert property (ref_osc_output == !$past(ref_osc_input, 3))
    else $error("oscillator output copy wrong");
  cover property ($rose(both_low));
  cover property ($fell(phi_vco_n) && phi_ref_n);
  cover property ($fell(phi_ref_n) && phi_vco_n);
endmodule
bind pll_synth_core pll_synth_core_assertions chk_u (.clk, .sys_rst, .ref_osc_input,
  .vco_input, .prog_level, .prog_drive, .ref_osc_output, .single_ended_phase_error_i,
  .single_ended_phase_error_o, .single_ended_phase_error_oe, .phi_vco_n, .phi_ref_n,
  .divn_out, .lock_det);
`default_nettype wire

// [sim/pll_far_end.sv]
// far side: vco and reference sources plus programming switches
`default_nettype none
module pll_far_end (
  // clock
  input wire logic clk,
  // pins into the core
  output logic vco_input,
  output logic ref_osc_input,
  output synth_pkg::prog_pins_t prog_level,
  output synth_pkg::prog_pins_t prog_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  import synth_pkg::*;
  initial begin
    vco_input = 1'b0;
    ref_osc_input = 1'b0;
    prog_level = '1;
    prog_drive = '1;
  end
  // caller keeps n within 3..16383
  task automatic set_prog(input prog_pins_t lvl, input prog_pins_t drv);
    @(posedge clk);
    prog_level <= lvl;
    prog_drive <= drv;
  endtask
  // 2 clk high and 3 low: shorter pulses may slip past the synchronizer
  task automatic edges(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      vco_input <= 1'b1;
      ref_osc_input <= 1'b1;
      repeat (2) @(posedge clk);
      vco_input <= 1'b0;
      ref_osc_input <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// [sim/pll_synth_core_test.sv]
// self-checking bench for the synthesizer core
`default_nettype none
module pll_synth_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic vco_input, ref_osc_input, pd_o, pd_oe, phi_vco_n, phi_ref_n, divn_out, lock_det;
  logic coin_d, div_d;
  prog_pins_t prog_level, prog_drive;
  int err_count = 0, check_count = 0, cyc = 0, coin_cnt = 0, div_cnt = 0;
  int ratio_tab [8] = '{8, 128, 256, 512, 1024, 2048, 2410, 8192};
  always #4 clk = ~clk;
  pll_far_end far_u (.clk, .vco_input, .ref_osc_input, .prog_level, .prog_drive);
  pll_synth_core dut_u (.clk, .sys_rst, .ref_osc_input, .ref_osc_output(), .vco_input,
    .prog_level, .prog_drive, .single_ended_phase_error_i(), .single_ended_phase_error_o(pd_o),
    .single_ended_phase_error_oe(pd_oe), .phi_vco_n, .phi_ref_n, .divn_out, .lock_det);
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    coin_d <= !phi_vco_n && !phi_ref_n;
    div_d <= divn_out;
    if (sys_rst) begin
      coin_cnt <= 0;
      div_cnt <= 0;
    end else begin
      if (!phi_vco_n && !phi_ref_n && !coin_d) coin_cnt <= coin_cnt + 1;
      if (divn_out && !div_d) div_cnt <= div_cnt + 1;
    end
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // open pins carry level 0 so only the pull-up can make them read one
  task automatic start(input logic [2:0] code, input logic [13:0] n, input logic tx,
    input prog_pins_t open);
    far_u.set_prog(prog_pins_t'({code, tx, n}) & ~open, ~open);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic run(input int cnt);
    far_u.edges(cnt);
    repeat (8) @(posedge clk);
  endtask
  task automatic chk_state(input logic v, input logic r);
    chk("phi_vco_n", !v, phi_vco_n);
    chk("phi_ref_n", !r, phi_ref_n);
    chk("pd_oe", v | r, pd_oe);
    if (v | r) chk("pd_o", r, pd_o);
    chk("lock_det", !(v | r), lock_det);
  endtask
  // n equal to r: every comparison coincident, one each r edges
  task automatic run_pair(input int r);
    run(1);
    chk("coin_first", 1, coin_cnt[15:0]);
    run(r - 1);
    chk("coin_early", 1, coin_cnt[15:0]);
    run(1);
    chk("coin_period", 2, coin_cnt[15:0]);
    chk("div_edges", 2, div_cnt[15:0]);
    chk_state(1'b0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic ratio_table();
    for (int c = 0; c < 8; c++) begin
      start(3'(c), 14'(ratio_tab[c]), 1'b0, c[0] ? 18'h0c000 : 18'h04000);
      run_pair(ratio_tab[c]);
    end
    $display("test ratio_table done");
  endtask
  task automatic offset_case();
    start(3'h6, 14'h0612, 1'b0, 18'h00002);
    run_pair(2410);
    $display("test offset_case done");
  endtask
  task automatic lead_cases();
    start(3'h0, 14'h0009, 1'b1, 18'h00000);
    run(9);
    chk_state(1'b0, 1'b1);
    run(1);
    chk("coin_lag", 2, coin_cnt[15:0]);
    chk_state(1'b0, 1'b0);
    start(3'h0, 14'h0003, 1'b1, 18'h00000);
    run(4);
    chk_state(1'b1, 1'b0);
    run(5);
    chk("coin_lead", 2, coin_cnt[15:0]);
    chk_state(1'b0, 1'b0);
    $display("test lead_cases done");
  endtask
  initial begin
    ratio_table();
    offset_case();
    lead_cases();
    end_sim();
  end
endmodule
`default_nettype wire
